// *** tss_map.svh ***
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH

// register byte offsets
`define TSS_OFF_CTRL      8'h00
`define TSS_OFF_STAT      8'h04
`define TSS_OFF_ADJ       8'h08
`define TSS_OFF_HOLD      8'h0C
`define TSS_OFF_LIM0      8'h10
`define TSS_OFF_LIM1      8'h14
`define TSS_OFF_CNT0      8'h18
`define TSS_OFF_CNT1      8'h1C
`define TSS_OFF_EVT       8'h20
`define TSS_OFF_MASK      8'h24

// control register fields
`define TSS_CTRL_EN       0
`define TSS_CTRL_RESTART  1

// status register fields
`define TSS_STAT_RUN      0
`define TSS_STAT_WAIT     1
`define TSS_STAT_QPTR_LO  8
`define TSS_STAT_CHAN_LO  16

// event bits
`define TSS_EV_IRQ        0
`define TSS_EV_EDGE       1
`define TSS_EV_LIMIT      2

// control step option that clears both loop counters
`define TSS_CTRL_CLRCNT   4'h1

// reset values
`define TSS_RST_WORD16    16'h0000
`define TSS_RST_CHAN      5'h00
`define TSS_RST_QPTR      5'h00

// axi responses
`define TSS_RESP_OKAY     2'h0
`define TSS_RESP_SLVERR   2'h2

`endif

// *** tss_pkg.sv ***
package tss_pkg;

   typedef enum logic [1:0] {TSS_IDLE, TSS_RUN, TSS_WAIT} tss_fsm_t;

   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] opt;
      logic [4:0] addr;
   } tss_step_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } tss_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tss_axi_rsp_t;

   typedef struct packed {
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
   } tss_sync_t;

   typedef struct packed {
      tss_fsm_t    fsm;
      logic        en;
      logic [4:0]  qptr;
      logic [15:0] adj;
      logic [15:0] hold;
      logic [15:0] lim0;
      logic [15:0] lim1;
      logic [15:0] c0;
      logic [15:0] c1;
      logic [4:0]  chan;
      logic [31:0] trig;
      logic [15:0] irq_out;
      logic [2:0]  ev;
      logic [2:0]  mask;
      logic        aw_have;
      logic [7:0]  awaddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tss_state_t;

endpackage : tss_pkg

// *** tss_decode.sv ***
`timescale 1ns/1ns
module tss_decode (
   // step byte
   input  wire logic [7:0]        i_byte,
   // split fields
   output tss_pkg::tss_step_t     o_step
);
   import tss_pkg::*;

   assign o_step.cmd  = i_byte[7:4];
   assign o_step.opt  = i_byte[3:0];
   assign o_step.addr = {i_byte[4], i_byte[3:0]};

endmodule : tss_decode

// *** tss_edge.sv ***
`timescale 1ns/1ns
module tss_edge (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // trigger pins
   input  wire logic [15:0] i_pins,
   // edge pulses
   output logic      [15:0] o_rise,
   output logic      [15:0] o_fall
);
   import tss_pkg::*;

   tss_sync_t st;
   tss_sync_t next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = i_pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // edges are judged only on the settled second and third stages
   genvar g;
   for (g = 0; g < 16; g = g + 1) begin : g_edge
      assign o_rise[g] = st.s2[g] & ~st.s3[g];
      assign o_fall[g] = ~st.s2[g] & st.s3[g];
   end

endmodule : tss_edge

// *** tss_sequencer.sv ***
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "tss_map.svh"
// Contract
// - each step byte splits into a command in the upper nibble and an option in the lower, command 0000 runs a control op.
// - command 0001 adds the adjust register to the target register chosen by the option.
// - a copy step loads the hold register into the target register chosen by the option.
// - commands 001x write command bit 0 and the option as five bits into the adc channel select field.
// - command 0100 stalls the queue until a rising edge on the trigger input chosen by the option.
// - command 0101 stalls the queue until a falling edge on the trigger input chosen by the option.
// - command 0110 and every reserved command or option executes with no effect.
// - command 0111 raises the one interrupt request chosen by the option.
// - commands 100x pulse the one trigger output chosen by command bit 0 and the option.
// - commands 101x load the queue pointer with command bit 0 and the option and continue there.
// - commands 110x advance when counter 0 equals its limit, else increment counter 0 and jump.
// - commands 111x advance when counter 1 equals its limit, else increment counter 1 and jump.
module tss_sequencer (
   // clock and reset
   input  wire logic                  I_MCLK,
   input  wire logic                  I_SRST,
   // register bus
   input  wire tss_pkg::tss_axi_req_t I_AXI,
   output tss_pkg::tss_axi_rsp_t      O_AXI,
   // step queue
   output logic [4:0]                 O_STEP_ADDR,
   input  wire logic [7:0]            I_STEP_BYTE,
   // trigger inputs and outputs
   input  wire logic [15:0]           I_TRIG_IN,
   output logic [31:0]                O_TRIG_OUT,
   output logic [15:0]                O_STEP_IRQ,
   output logic [4:0]                 O_ADC_CHAN,
   // interrupt
   output logic                       O_IRQ
);
   import tss_pkg::*;

   tss_state_t  st;
   tss_state_t  next_st;
   tss_step_t   dec;
   logic [15:0] rise;
   logic [15:0] fall;
   logic        exec;
   logic        wr_go;
   logic [2:0]  ev_set;
   logic [2:0]  ev_clr;
   logic [4:0]  qnext;

   tss_decode u_decode (
      .i_byte (I_STEP_BYTE),
      .o_step (dec)
   );

   tss_edge u_edge (
      .i_clk  (I_MCLK),
      .i_rst  (I_SRST),
      .i_pins (I_TRIG_IN),
      .o_rise (rise),
      .o_fall (fall)
   );

   function automatic logic tss_mapped(input logic [7:0] a);
      tss_mapped = (a[1:0] == 2'h0) && (a <= `TSS_OFF_MASK);
   endfunction : tss_mapped

   function automatic logic [15:0] tss_merge16(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
      tss_merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : tss_merge16

   function automatic logic [31:0] tss_read(input logic [7:0] a);
      tss_read = 32'h0000_0000;
      case (a)
         `TSS_OFF_CTRL: tss_read[`TSS_CTRL_EN] = st.en;
         `TSS_OFF_STAT: begin
            tss_read[`TSS_STAT_RUN]  = (st.fsm == TSS_RUN);
            tss_read[`TSS_STAT_WAIT] = (st.fsm == TSS_WAIT);
            tss_read[`TSS_STAT_QPTR_LO +: 5] = st.qptr;
            tss_read[`TSS_STAT_CHAN_LO +: 5] = st.chan;
         end
         `TSS_OFF_ADJ:  tss_read[15:0] = st.adj;
         `TSS_OFF_HOLD: tss_read[15:0] = st.hold;
         `TSS_OFF_LIM0: tss_read[15:0] = st.lim0;
         `TSS_OFF_LIM1: tss_read[15:0] = st.lim1;
         `TSS_OFF_CNT0: tss_read[15:0] = st.c0;
         `TSS_OFF_CNT1: tss_read[15:0] = st.c1;
         `TSS_OFF_EVT:  tss_read[2:0]  = st.ev;
         `TSS_OFF_MASK: tss_read[2:0]  = st.mask;
         default:       tss_read = 32'h0000_0000;
      endcase
   endfunction : tss_read

   assign exec  = st.en && (st.fsm != TSS_IDLE);
   assign wr_go = st.aw_have && st.w_have && !st.bvalid;
   assign qnext = st.qptr + 5'h01;

   always_comb begin
      next_st         = st;
      next_st.trig    = 32'h0000_0000;
      next_st.irq_out = 16'h0000;
      ev_set          = 3'h0;
      ev_clr          = 3'h0;

      // step execution, one step per clock
      if (!st.en) begin
         next_st.fsm = TSS_IDLE;
      end else if (st.fsm == TSS_IDLE) begin
         next_st.fsm = TSS_RUN;
      end else begin
         next_st.fsm  = TSS_RUN;
         next_st.qptr = qnext;
         casez (dec.cmd)
            4'b0000: begin
               if (dec.opt == `TSS_CTRL_CLRCNT) begin
                  next_st.c0 = `TSS_RST_WORD16;
                  next_st.c1 = `TSS_RST_WORD16;
               end
            end
            4'b0001: begin
               // option bit 3 picks copy over add, bit 2 set is reserved
               if (!dec.opt[2]) begin
                  case (dec.opt[1:0])
                     2'h0: next_st.lim0 = dec.opt[3] ? st.hold : st.lim0 + st.adj;
                     2'h1: next_st.lim1 = dec.opt[3] ? st.hold : st.lim1 + st.adj;
                     2'h2: next_st.c0   = dec.opt[3] ? st.hold : st.c0 + st.adj;
                     default: next_st.c1 = dec.opt[3] ? st.hold : st.c1 + st.adj;
                  endcase
               end
            end
            4'b001?: next_st.chan = dec.addr;
            4'b0100: begin
               if (rise[dec.opt]) begin
                  ev_set[`TSS_EV_EDGE] = 1'b1;
               end else begin
                  next_st.qptr = st.qptr;
                  next_st.fsm  = TSS_WAIT;
               end
            end
            4'b0101: begin
               if (fall[dec.opt]) begin
                  ev_set[`TSS_EV_EDGE] = 1'b1;
               end else begin
                  next_st.qptr = st.qptr;
                  next_st.fsm  = TSS_WAIT;
               end
            end
            4'b0111: begin
               next_st.irq_out[dec.opt] = 1'b1;
               ev_set[`TSS_EV_IRQ]      = 1'b1;
            end
            4'b100?: next_st.trig[dec.addr] = 1'b1;
            4'b101?: next_st.qptr = dec.addr;
            4'b110?: begin
               if (st.c0 == st.lim0) begin
                  ev_set[`TSS_EV_LIMIT] = 1'b1;
               end else begin
                  next_st.c0   = st.c0 + 16'h0001;
                  next_st.qptr = dec.addr;
               end
            end
            4'b111?: begin
               if (st.c1 == st.lim1) begin
                  ev_set[`TSS_EV_LIMIT] = 1'b1;
               end else begin
                  next_st.c1   = st.c1 + 16'h0001;
                  next_st.qptr = dec.addr;
               end
            end
            default: next_st.qptr = qnext;
         endcase
      end

      // write channel capture, address and data in either order
      if (I_AXI.awvalid && O_AXI.awready) begin
         next_st.aw_have = 1'b1;
         next_st.awaddr  = I_AXI.awaddr;
      end
      if (I_AXI.wvalid && O_AXI.wready) begin
         next_st.w_have = 1'b1;
         next_st.wdata  = I_AXI.wdata;
         next_st.wstrb  = I_AXI.wstrb;
      end

      // software writes land after the step, so software wins a clash on every register but the event bits
      if (wr_go) begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = tss_mapped(st.awaddr) ? `TSS_RESP_OKAY : `TSS_RESP_SLVERR;
         case (st.awaddr)
            `TSS_OFF_CTRL: begin
               if (st.wstrb[0]) begin
                  next_st.en = st.wdata[`TSS_CTRL_EN];
                  if (st.wdata[`TSS_CTRL_RESTART]) begin
                     next_st.qptr = `TSS_RST_QPTR;
                  end
               end
            end
            `TSS_OFF_ADJ:  next_st.adj  = tss_merge16(st.adj, st.wdata, st.wstrb);
            `TSS_OFF_HOLD: next_st.hold = tss_merge16(st.hold, st.wdata, st.wstrb);
            `TSS_OFF_LIM0: next_st.lim0 = tss_merge16(st.lim0, st.wdata, st.wstrb);
            `TSS_OFF_LIM1: next_st.lim1 = tss_merge16(st.lim1, st.wdata, st.wstrb);
            `TSS_OFF_CNT0: next_st.c0   = tss_merge16(st.c0, st.wdata, st.wstrb);
            `TSS_OFF_CNT1: next_st.c1   = tss_merge16(st.c1, st.wdata, st.wstrb);
            `TSS_OFF_EVT:  ev_clr       = st.wstrb[0] ? st.wdata[2:0] : 3'h0;
            `TSS_OFF_MASK: begin
               if (st.wstrb[0]) begin
                  next_st.mask = st.wdata[2:0];
               end
            end
            default: next_st.bvalid = 1'b1;
         endcase
      end
      if (st.bvalid && I_AXI.bready) begin
         next_st.bvalid = 1'b0;
      end

      // read answers one cycle after the address is taken
      if (st.rvalid) begin
         if (I_AXI.rready) begin
            next_st.rvalid = 1'b0;
         end
      end else if (I_AXI.arvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = tss_read(I_AXI.araddr);
         next_st.rresp  = tss_mapped(I_AXI.araddr) ? `TSS_RESP_OKAY : `TSS_RESP_SLVERR;
      end

      // an event in the clearing cycle survives
      next_st.ev = (st.ev & ~ev_clr) | ev_set;
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign O_AXI.awready = !st.aw_have && !st.bvalid;
   assign O_AXI.wready  = !st.w_have && !st.bvalid;
   assign O_AXI.bvalid  = st.bvalid;
   assign O_AXI.bresp   = st.bresp;
   assign O_AXI.arready = !st.rvalid;
   assign O_AXI.rvalid  = st.rvalid;
   assign O_AXI.rdata   = st.rdata;
   assign O_AXI.rresp   = st.rresp;
   assign O_STEP_ADDR   = st.qptr;
   assign O_TRIG_OUT    = st.trig;
   assign O_STEP_IRQ    = st.irq_out;
   assign O_ADC_CHAN    = st.chan;
   assign O_IRQ         = |(st.ev & st.mask);

   a_ctrl_clear: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h0 && dec.opt == `TSS_CTRL_CLRCNT |=> st.c0 == 16'h0000 && st.c1 == 16'h0000)
      else $error("control step did not clear the loop counters");

   a_add_limit: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h1 && dec.opt == 4'h0 |=> st.lim0 == $past(st.lim0) + $past(st.adj))
      else $error("add step did not add the adjust value");

   a_copy_hold: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h1 && dec.opt == 4'hB |=> st.c1 == $past(st.hold))
      else $error("copy step did not load the hold value");

   a_chan_strobe: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      exec && dec.cmd[3:1] == 3'b001 |=> O_ADC_CHAN == $past(dec.addr))
      else $error("channel select not written from the step");

   a_wait_rise: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h4 && !rise[dec.opt] |=> st.qptr == $past(st.qptr) && st.fsm == TSS_WAIT)
      else $error("rising wait did not stall");

   a_wait_fall: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h5 && fall[dec.opt] |=> st.qptr == $past(qnext))
      else $error("falling wait did not advance on its edge");

   a_reserved_nop: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd == 4'h6 |=> st.qptr == $past(qnext) && $stable(st.chan) && O_TRIG_OUT == 32'h0)
      else $error("reserved step had an effect");

   a_irq_pulse: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      exec && dec.cmd == 4'h7 |=> O_STEP_IRQ == (16'h0001 << $past(dec.opt))
      ##1 (O_STEP_IRQ == 16'h0 || ($past(exec) && $past(dec.cmd) == 4'h7)))
      else $error("interrupt request not a single one-cycle pulse");

   a_trig_pulse: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      exec && dec.cmd[3:1] == 3'b100 |=> O_TRIG_OUT == (32'h0000_0001 << $past(dec.addr)))
      else $error("trigger output not the selected one");

   a_jump_load: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd[3:1] == 3'b101 |=> O_STEP_ADDR == $past(dec.addr))
      else $error("jump did not load the pointer");

   a_loop_zero: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd[3:1] == 3'b110 && st.c0 != st.lim0
      |=> st.c0 == $past(st.c0) + 16'h0001 && st.qptr == $past(dec.addr))
      else $error("counter 0 loop jump wrong");

   a_loop_one: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd[3:1] == 3'b111 && st.c1 == st.lim1 |=> st.qptr == $past(qnext) && $stable(st.c1))
      else $error("counter 1 loop at limit did not fall through");

   a_step_advance: assert property (@(posedge I_MCLK) disable iff (I_SRST || wr_go)
      exec && dec.cmd[3:1] == 3'b001 |=> st.qptr == $past(st.qptr) + 5'h01)
      else $error("pointer did not advance after a plain step");

endmodule : tss_sequencer

// *** tss_queue_model.sv ***
`timescale 1ns/1ns
module tss_queue_model (
   // step fetch
   input  wire logic [4:0] i_addr,
   output logic      [7:0] o_byte
);
   // loaded by the bench only while the sequencer is stopped, so a fetch never sees a half-written program
   logic [7:0] mem [32];

   // combinational answer in the same cycle as the address
   assign o_byte = mem[i_addr];
endmodule : tss_queue_model

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "tss_map.svh"
module tb_top;
   import tss_pkg::*;

   typedef struct {
      logic [7:0]  b;
      logic [4:0]  ptr;
      logic [31:0] trig;
      logic [15:0] irq;
      logic [4:0]  chan;
   } tss_row_t;

   logic         clk        = 1'b0;
   logic         srst       = 1'b1;
   tss_axi_req_t axi        = '0;
   tss_axi_rsp_t rsp;
   logic [4:0]   step_addr;
   logic [7:0]   step_byte;
   logic [15:0]  pins       = 16'h0004;
   logic [31:0]  trig;
   logic [15:0]  irq_step;
   logic [4:0]   chan;
   logic         irq;
   int           failures   = 0;
   int           n_compared = 0;
   int           trig_cnt;
   int           irq_cnt;
   logic [31:0]  trig_last;
   logic [15:0]  irq_last;
   logic [31:0]  d;
   logic [1:0]   r;
   tss_row_t     rows [10];

   always #4 clk = ~clk;

   tss_sequencer tss_sequencer_inst (
      .I_MCLK      (clk),
      .I_SRST      (srst),
      .I_AXI       (axi),
      .O_AXI       (rsp),
      .O_STEP_ADDR (step_addr),
      .I_STEP_BYTE (step_byte),
      .I_TRIG_IN   (pins),
      .O_TRIG_OUT  (trig),
      .O_STEP_IRQ  (irq_step),
      .O_ADC_CHAN  (chan),
      .O_IRQ       (irq)
   );

   tss_queue_model tss_queue_model_inst (
      .i_addr (step_addr),
      .o_byte (step_byte)
   );

   // pulses last one cycle, so the falling edge sees each exactly once
   always @(negedge clk) begin
      if (trig !== 32'h0) begin
         trig_cnt++;
         trig_last = trig;
      end
      if (irq_step !== 16'h0) begin
         irq_cnt++;
         irq_last = irq_step;
      end
   end

   task automatic conclude();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int   n;
      logic ahs;
      logic whs;
      logic bv;
      @(posedge clk);
      axi.awvalid <= 1'b1;
      axi.awaddr  <= a;
      axi.wvalid  <= 1'b1;
      axi.wdata   <= v;
      axi.wstrb   <= 4'hF;
      axi.bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         // values at the falling edge are those the next rising edge samples
         @(negedge clk);
         ahs = axi.awvalid & rsp.awready;
         whs = axi.wvalid & rsp.wready;
         bv  = rsp.bvalid;
         r   = rsp.bresp;
         @(posedge clk);
         if (ahs) axi.awvalid <= 1'b0;
         if (whs) axi.wvalid <= 1'b0;
         if (bv) begin
            axi.bready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         failures++;
         conclude();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int   n;
      logic ahs;
      logic rv;
      @(posedge clk);
      axi.arvalid <= 1'b1;
      axi.araddr  <= a;
      axi.rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clk);
         ahs = axi.arvalid & rsp.arready;
         rv  = rsp.rvalid;
         d   = rsp.rdata;
         r   = rsp.rresp;
         @(posedge clk);
         if (ahs) axi.arvalid <= 1'b0;
         if (rv) begin
            axi.rready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         failures++;
         conclude();
      end
   endtask : rd

   // every unused slot jumps to itself, so a program parks after its last step
   task automatic load(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      int i;
      wr(`TSS_OFF_CTRL, 32'h0);
      for (i = 0; i < 32; i++) tss_queue_model_inst.mem[i] = 8'hA0 + 8'(i);
      tss_queue_model_inst.mem[0] = b0;
      tss_queue_model_inst.mem[1] = b1;
      tss_queue_model_inst.mem[2] = b2;
   endtask : load

   task automatic go(input int n);
      wr(`TSS_OFF_CTRL, 32'h3);
      trig_cnt  = 0;
      irq_cnt   = 0;
      trig_last = 32'h0;
      irq_last  = 16'h0;
      repeat (n) @(posedge clk);
   endtask : go

   task automatic loop_run(input logic [7:0] lo, input logic [7:0] co, input logic [7:0] tb, input logic [7:0] jb,
                           input logic [31:0] lim);
      wr(`TSS_OFF_EVT, 32'h4);
      wr(lo, lim);
      wr(co, 32'h0);
      load(tb, jb, 8'hA2);
      go(40);
      check("loop pulses", 32'(trig_cnt), lim + 32'h1);
      rd(co);
      check("loop count", d, lim);
      rd(`TSS_OFF_STAT);
      check("loop exit", 32'(d[12:8]), 32'h2);
      rd(`TSS_OFF_EVT);
      check("limit event", 32'(d[2]), 32'h1);
   endtask : loop_run

   initial begin
      rows = '{'{8'h2A, 5'h01, 32'h0, 16'h0, 5'h0A},
               '{8'h35, 5'h01, 32'h0, 16'h0, 5'h15},
               '{8'h83, 5'h01, 32'h0000_0008, 16'h0, 5'h15},
               '{8'h9F, 5'h01, 32'h8000_0000, 16'h0, 5'h15},
               '{8'h75, 5'h01, 32'h0, 16'h0020, 5'h15},
               '{8'h60, 5'h01, 32'h0, 16'h0, 5'h15},
               '{8'h00, 5'h01, 32'h0, 16'h0, 5'h15},
               '{8'h0F, 5'h01, 32'h0, 16'h0, 5'h15},
               '{8'hA5, 5'h05, 32'h0, 16'h0, 5'h15},
               '{8'hBF, 5'h1F, 32'h0, 16'h0, 5'h15}};
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(`TSS_OFF_STAT);
      check("status after reset", d, 32'h0);
      check("channel after reset", 32'(chan), 32'h0);
      foreach (rows[k]) begin
         load(rows[k].b, 8'hA1, 8'hA2);
         go(12);
         rd(`TSS_OFF_STAT);
         check("pointer", 32'(d[12:8]), 32'(rows[k].ptr));
         check("trigger out", trig_last, rows[k].trig);
         check("step irq", 32'(irq_last), 32'(rows[k].irq));
         check("channel", 32'(chan), 32'(rows[k].chan));
      end
      wr(`TSS_OFF_ADJ, 32'h5);
      wr(`TSS_OFF_LIM0, 32'h10);
      wr(`TSS_OFF_HOLD, 32'h1234);
      wr(`TSS_OFF_LIM1, 32'h100);
      load(8'h10, 8'h1B, 8'h15);
      go(12);
      rd(`TSS_OFF_LIM0);
      check("add target", d, 32'h15);
      rd(`TSS_OFF_CNT1);
      check("copy target", d, 32'h1234);
      rd(`TSS_OFF_LIM1);
      check("reserved option", d, 32'h100);
      load(8'h1A, 8'h11, 8'hA2);
      go(12);
      rd(`TSS_OFF_CNT0);
      check("copy to counter 0", d, 32'h1234);
      rd(`TSS_OFF_LIM1);
      check("add to limit 1", d, 32'h105);
      loop_run(`TSS_OFF_LIM0, `TSS_OFF_CNT0, 8'h83, 8'hC0, 32'h3);
      loop_run(`TSS_OFF_LIM1, `TSS_OFF_CNT1, 8'h84, 8'hE0, 32'h1);
      load(8'h01, 8'hA1, 8'hA2);
      go(12);
      rd(`TSS_OFF_CNT0);
      check("cleared counter 0", d, 32'h0);
      rd(`TSS_OFF_CNT1);
      check("cleared counter 1", d, 32'h0);
      wr(`TSS_OFF_EVT, 32'h7);
      load(8'h43, 8'h52, 8'h77);
      go(12);
      rd(`TSS_OFF_STAT);
      check("rise wait pointer", 32'(d[12:8]), 32'h0);
      check("wait flag", 32'(d[1]), 32'h1);
      pins <= 16'h000C;
      repeat (12) @(posedge clk);
      rd(`TSS_OFF_STAT);
      check("fall wait pointer", 32'(d[12:8]), 32'h1);
      check("irq before fall", 32'(irq_cnt), 32'h0);
      pins <= 16'h0008;
      repeat (12) @(posedge clk);
      rd(`TSS_OFF_STAT);
      check("after waits", 32'(d[12:8]), 32'h3);
      check("irq after fall", 32'(irq_last), 32'h0080);
      check("masked irq", 32'(irq), 32'h0);
      wr(`TSS_OFF_MASK, 32'h1);
      check("unmasked irq", 32'(irq), 32'h1);
      wr(`TSS_OFF_EVT, 32'h1);
      check("cleared irq", 32'(irq), 32'h0);
      rd(`TSS_OFF_EVT);
      check("events left", d, 32'h2);
      wr(8'h40, 32'hFFFF_FFFF);
      check("unmapped write", 32'(r), 32'h2);
      rd(8'h40);
      check("unmapped read", 32'(r), 32'h2);
      check("unmapped data", d, 32'h0);
      // reset while a program is running must drop every register back
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(`TSS_OFF_STAT);
      check("status after mid reset", d, 32'h0);
      rd(`TSS_OFF_MASK);
      check("mask after mid reset", d, 32'h0);
      check("channel after mid reset", 32'(chan), 32'h0);
      conclude();
   end
endmodule : tb_top
